/* File: pcbnk_regs.vh */
`ifndef PCBNK_REGS_VH
`define PCBNK_REGS_VH
// Register byte offsets
`define PCBNK_OFS_SAMPLE     8'h7c
`define PCBNK_OFS_DOWN_IO_RD 8'h80
`define PCBNK_OFS_DOWN_IO_WR 8'h84
`define PCBNK_OFS_DOWN_MEM_RD 8'h88
`define PCBNK_OFS_DOWN_MEM_WR 8'h8c
`define PCBNK_OFS_UP_IO_RD   8'h90
`define PCBNK_OFS_UP_IO_WR   8'h94
`define PCBNK_OFS_UP_MEM_RD  8'h98
`define PCBNK_OFS_UP_MEM_WR  8'h9c
`define PCBNK_OFS_SLOT_CAP   8'hb0
`define PCBNK_OFS_HS_CAP     8'hc0
// Counter bank base and count
`define PCBNK_CNT_BASE       8'h80
`define PCBNK_NUM_CNT        8
// Capability codes and links
`define PCBNK_SLOT_CAP_CODE  8'h04
`define PCBNK_HS_CAP_CODE    8'h06
`define PCBNK_SLOT_LINK_HS   8'hc0
`define PCBNK_LINK_END       8'h00
// Field positions
`define PCBNK_SLOT_NUM_LSB   16
`define PCBNK_SLOT_NUM_MSB   20
`define PCBNK_FIRST_CHASSIS  21
`define PCBNK_CHASSIS_LSB    24
`define PCBNK_ENUM_EN_BIT    17
`define PCBNK_LED_BIT        19
`define PCBNK_EXT_STAT_BIT   22
`define PCBNK_INS_STAT_BIT   23
// Reset values
`define PCBNK_RST_WORD       32'h0000_0000
`endif

/* File: pcbnk_counter.v */
`include "pcbnk_regs.vh"
// One writable event counter; software write beats the increment
module pcbnk_counter (
  input  wire        sys_clk,
  input  wire        resetn,
  input  wire        wr_en,
  input  wire [31:0] wr_data,
  input  wire        window_on,
  input  wire        event_in,
  output reg  [31:0] count
);
  // Count only within the window, hold otherwise
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count <= `PCBNK_RST_WORD;
    end else if (wr_en) begin
      count <= wr_data;
    end else if (window_on && event_in) begin
      count <= count + 32'h0000_0001;
    end
  end
endmodule

/* File: pcbnk_bank.v */
`include "pcbnk_regs.vh"

// Counters wrap silently at the top of their range; software
// that wants long runs must read them before they wrap; they hold after the window ends.
// A software write to a counter beats a completion in the same
// clock, so a value written while traffic flows can lose one count.
// The slot link byte follows the strap live, so a strap that moves
// after power-up changes what software sees without any write.
// Reads are registered: the word stands from the cycle after the
// read strobe until the next read strobe.
// The timer counts bus clocks; a new write restarts the window
// from the written value instead of adding to what is left.
module pcbnk_bank (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        resetn,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Strap and per-port completion pulses
  input  wire        hot_swap_strap,
  input  wire        down_io_rd_done,
  input  wire        down_io_wr_done,
  input  wire        down_mem_rd_done,
  input  wire        down_mem_wr_done,
  input  wire        up_io_rd_done,
  input  wire        up_io_wr_done,
  input  wire        up_mem_rd_done,
  input  wire        up_mem_wr_done,
  // Hot-swap pins and window status
  input  wire        enum_alert_req,
  output wire        enum_alert_out,
  output wire        led_drive_out,
  output wire        window_active
);
  // Sampling timer remaining count
  reg  [31:0] sample_left;
  // Slot entry writable fields
  reg  [4:0]  slot_number;
  reg         first_in_chassis;
  reg  [7:0]  chassis_number;
  // Hot-swap writable fields
  reg         enum_enable;
  reg         led_off;
  reg         ext_status;
  reg         ins_status;
  // Counter values, flattened
  wire [255:0] cnt_flat;
  // Per-counter events in offset order
  wire [7:0]  cnt_event;
  // Word hits
  wire        hit_sample;
  wire        hit_slot;
  wire        hit_hs;
  wire        hit_cnt;
  // Counter index from address bits 4:2
  wire [2:0]  cnt_idx;
  // Next read word
  reg  [31:0] next_rdata;
  // One-hot counter select from the word index
  wire [7:0]  cnt_sel;
  // Per-counter software write enables
  wire [7:0]  cnt_wr;
  // Word-level write strobes, one per register; the eight counters share one
  wire        wr_sample;
  wire        wr_slot;
  wire        wr_hs;
  wire        wr_cnt;
  // Next state of the sampling timer
  reg  [31:0] next_sample_left;
  // Next state of the slot entry fields
  reg  [4:0]  next_slot_number;
  reg         next_first_in_chassis;
  reg  [7:0]  next_chassis_number;
  // Next state of the hot-swap fields
  reg         next_enum_enable;
  reg         next_led_off;
  reg         next_ext_status;
  reg         next_ins_status;
  // Assembled read words of the two capability entries
  wire [31:0] slot_word;
  wire [31:0] hs_word;
  // Counter word picked by the index
  reg  [31:0] cnt_word;
  // Link byte of the slot entry, strap dependent
  wire [7:0]  slot_link;

  assign window_active = (sample_left != 32'h0000_0000);
  assign hit_sample = (reg_addr == `PCBNK_OFS_SAMPLE);
  assign hit_slot   = (reg_addr == `PCBNK_OFS_SLOT_CAP);
  assign hit_hs     = (reg_addr == `PCBNK_OFS_HS_CAP);
  // Counters occupy 0x80..0x9c
  assign hit_cnt    = (reg_addr[7:5] == 3'h4) && (reg_addr[1:0] == 2'h0);
  assign cnt_idx    = reg_addr[4:2];

  // Write strobes qualified by the word decode
  assign wr_sample  = reg_wr && hit_sample;
  assign wr_slot    = reg_wr && hit_slot;
  assign wr_hs      = reg_wr && hit_hs;
  assign wr_cnt     = reg_wr && hit_cnt;
  // One-hot select; the shift stays within eight bits
  assign cnt_sel    = 8'h01 << cnt_idx;
  // Only the addressed counter sees a write
  assign cnt_wr     = cnt_sel & {8{wr_cnt}};

  // Completion pulses, one per transaction
  assign cnt_event = {up_mem_wr_done,   // Index 7, upstream memory writes
                      up_mem_rd_done,   // Index 6, upstream memory reads
                      up_io_wr_done,    // Index 5, upstream I/O writes
                      up_io_rd_done,    // Index 4, upstream I/O reads
                      down_mem_wr_done, // Index 3, downstream memory writes
                      down_mem_rd_done, // Index 2, downstream memory reads
                      down_io_wr_done,  // Index 1, downstream I/O writes
                      down_io_rd_done}; // Index 0

  // Eight counters, window gated
  // Counters see the window level, not the timer value, so a
  // rewrite of the timer mid-window never drops a count
  genvar gi;
  generate
    for (gi = 0; gi < `PCBNK_NUM_CNT; gi = gi + 1) begin : g_cnt
      // Each counter owns one word of the flat bus
      pcbnk_counter u_cnt (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .wr_en     (cnt_wr[gi]),
        .wr_data   (reg_wdata),
        .window_on (window_active),
        .event_in  (cnt_event[gi]),
        .count     (cnt_flat[gi*32 +: 32])
      );
    end
  endgenerate

  // Timer next value: a write restarts it, otherwise it runs down
  always @* begin
    next_sample_left = sample_left;
    if (wr_sample) begin
      // Software write wins over the countdown
      next_sample_left = reg_wdata;
    end else if (window_active) begin
      // One bus clock elapsed inside the window
      next_sample_left = sample_left - 32'h0000_0001;
    end else begin
      // Expired or never started: stays cleared
      next_sample_left = `PCBNK_RST_WORD;
    end
  end

  // Sampling timer register; zero means the window is closed
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      // Reset closes the window
      sample_left <= `PCBNK_RST_WORD;
    end else begin
      // Take the next value every clock
      sample_left <= next_sample_left;
    end
  end

  // Slot entry next values; only the writable fields follow a write
  always @* begin
    next_slot_number      = slot_number;
    next_first_in_chassis = first_in_chassis;
    next_chassis_number   = chassis_number;
    if (wr_slot) begin
      // Code, link and reserved bits of the write are dropped
      next_slot_number      = reg_wdata[`PCBNK_SLOT_NUM_MSB:`PCBNK_SLOT_NUM_LSB];
      next_first_in_chassis = reg_wdata[`PCBNK_FIRST_CHASSIS];
      next_chassis_number   = reg_wdata[31:`PCBNK_CHASSIS_LSB];
    end
  end

  // Slot identification entry registers
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      // All writable fields clear at reset
      slot_number      <= 5'h00;
      first_in_chassis <= 1'b0;
      chassis_number   <= 8'h00;
    end else begin
      // Hold or load as decided above
      slot_number      <= next_slot_number;
      first_in_chassis <= next_first_in_chassis;
      chassis_number   <= next_chassis_number;
    end
  end

  // Hot-swap next values; unused bits have no storage at all
  always @* begin
    next_enum_enable = enum_enable;
    next_led_off     = led_off;
    next_ext_status  = ext_status;
    next_ins_status  = ins_status;
    if (wr_hs) begin
      // Bits 15:0, 16, 18, 21:20 and 31:24 of the write are dropped
      next_enum_enable = reg_wdata[`PCBNK_ENUM_EN_BIT];
      next_led_off     = reg_wdata[`PCBNK_LED_BIT];
      next_ext_status  = reg_wdata[`PCBNK_EXT_STAT_BIT];
      next_ins_status  = reg_wdata[`PCBNK_INS_STAT_BIT];
    end
  end

  // Hot-swap control and status registers
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      // Reset masks the alert and lights the LED
      enum_enable <= 1'b0;
      led_off     <= 1'b0;
      ext_status  <= 1'b0;
      ins_status  <= 1'b0;
    end else begin
      // Hold or load as decided above
      enum_enable <= next_enum_enable;
      led_off     <= next_led_off;
      ext_status  <= next_ext_status;
      ins_status  <= next_ins_status;
    end
  end

  // Alert only passes when enabled; a masked request never leaves
  // the block, so the pin keeps no memory of it
  assign enum_alert_out = enum_alert_req && enum_enable;
  // Zero lights the LED; the output comes straight from a flop
  assign led_drive_out  = led_off;

  // Slot link points at the hot-swap entry only when strapped in
  assign slot_link = hot_swap_strap ? `PCBNK_SLOT_LINK_HS : `PCBNK_LINK_END;

  // Slot entry as read: chassis, reserved pair, flag, slot, link, code
  assign slot_word = {chassis_number,         // Bits 31:24
                      2'b00,                  // Reserved, read zero
                      first_in_chassis,       // Bit 21
                      slot_number,            // Bits 20:16
                      slot_link,              // Bits 15:8
                      `PCBNK_SLOT_CAP_CODE};  // Fixed code
  // Hot-swap entry as read; unused positions are constant zero
  assign hs_word   = {8'h00,                  // Reserved
                      ins_status,             // Bit 23
                      ext_status,             // Bit 22
                      2'b00,                  // Unused
                      led_off,                // Bit 19
                      1'b0,                   // Unused
                      enum_enable,            // Bit 17
                      1'b0,                   // Unused
                      `PCBNK_LINK_END,        // Last entry
                      `PCBNK_HS_CAP_CODE};    // Fixed code

  // Counter word picked by the index from address bits 4:2
  always @* begin
    cnt_word = 32'h0000_0000;
    case (cnt_idx)
      3'h0: begin
        // Downstream I/O reads
        cnt_word = cnt_flat[31:0];
      end
      3'h1: begin
        // Downstream I/O writes
        cnt_word = cnt_flat[63:32];
      end
      3'h2: begin
        // Downstream memory reads
        cnt_word = cnt_flat[95:64];
      end
      3'h3: begin
        // Downstream memory writes
        cnt_word = cnt_flat[127:96];
      end
      3'h4: begin
        // Upstream I/O reads
        cnt_word = cnt_flat[159:128];
      end
      3'h5: begin
        // Upstream I/O writes
        cnt_word = cnt_flat[191:160];
      end
      3'h6: begin
        // Upstream memory reads
        cnt_word = cnt_flat[223:192];
      end
      3'h7: begin
        // Upstream memory writes
        cnt_word = cnt_flat[255:224];
      end
      default: begin
        // Unreachable with a three-bit index
        cnt_word = 32'h0000_0000;
      end
    endcase
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    next_rdata = 32'h0000_0000;
    if (hit_cnt) begin
      // One of the eight transaction counters
      next_rdata = cnt_word;
    end else if (hit_sample) begin
      // Remaining time of the sampling window
      next_rdata = sample_left;
    end else if (hit_slot) begin
      // Slot identification entry
      next_rdata = slot_word;
    end else if (hit_hs) begin
      // Hot-swap entry
      next_rdata = hs_word;
    end else begin
      // Nothing mapped here
      next_rdata = 32'h0000_0000;
    end
  end

  // Read data registered, valid cycle after strobe and held after
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      // Reads nothing until the first strobe
      reg_rdata <= `PCBNK_RST_WORD;
    end else if (reg_rd) begin
      // Capture the addressed word at the strobe edge
      reg_rdata <= next_rdata;
    end
  end
endmodule

/* File: pcbnk_bank_monitor.sv */
module pcbnk_mon (
  input wire        sys_clk,
  input wire        resetn,
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        hot_swap_strap,
  input wire        enum_alert_req,
  input wire        enum_alert_out,
  input wire        led_drive_out,
  input wire        window_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Decoded accesses, read data lands one cycle later
  wire hs_wr  = reg_wr && reg_addr == 8'hc0;
  wire hs_rd  = reg_rd && reg_addr == 8'hc0;
  wire sl_rd  = reg_rd && reg_addr == 8'hb0;
  wire tmr_wr = reg_wr && reg_addr == 8'h7c;
  alert_mask_a: assert property (hs_wr && !reg_wdata[17] |=> !enum_alert_out)
    else $error("alert passes while masked");
  alert_req_a: assert property (enum_alert_out |-> enum_alert_req)
    else $error("alert without request");
  led_ctl_a: assert property (hs_wr |=> led_drive_out == $past(reg_wdata[19]))
    else $error("led output wrong");
  slot_read_a: assert property (sl_rd |=>
    reg_rdata[7:0] == 8'h04 && reg_rdata[23:22] == 2'b00)
    else $error("slot entry fixed bits wrong");
  slot_link_a: assert property (sl_rd |=>
    reg_rdata[15:8] == ($past(hot_swap_strap) ? 8'hc0 : 8'h00))
    else $error("slot link wrong");
  hs_read_a: assert property (hs_rd |=>
    (reg_rdata & 32'hff35_ffff) == 32'h0000_0006)
    else $error("hot swap fixed bits wrong");
  win_open_a: assert property (tmr_wr && reg_wdata != 0 |=> window_active)
    else $error("window did not open");
  win_len_a: assert property (tmr_wr && reg_wdata == 32'h0000_0003 |=>
    window_active [*3] ##1 !window_active)
    else $error("window length wrong");
endmodule
bind pcbnk_bank pcbnk_mon mon_u (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .hot_swap_strap, .enum_alert_req, .enum_alert_out, .led_drive_out, .window_active);

/* File: pcbnk_traffic.sv */
// Bridge ports: one completion pulse per requested transaction
module pcbnk_traffic (
  input  wire        sys_clk,
  input  wire  [7:0] go,
  output logic [7:0] done
);
  timeunit 1ns;
  timeprecision 1ns;
  initial done = 8'h00;
  always @(posedge sys_clk) done <= go;
endmodule

/* File: perf_counters_hotswap_caps_tb.sv */
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module perf_counters_hotswap_caps_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, strap = 1, areq = 0, rd_d = 0;
  logic [7:0] reg_addr = 8'h00, go = 8'h00, done;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, r, exp_v, base [8];
  logic aout, led, win;
  logic [31:0] q [$];
  int error_cnt = 0, samples_checked = 0, cyc = 0, seed = 32, nev [8];
  always #50 sys_clk = ~sys_clk;
  pcbnk_traffic far_u (.sys_clk, .go, .done);
  pcbnk_bank dut_u (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .hot_swap_strap(strap), .down_io_rd_done(done[0]), .down_io_wr_done(done[1]),
    .down_mem_rd_done(done[2]), .down_mem_wr_done(done[3]), .up_io_rd_done(done[4]),
    .up_io_wr_done(done[5]), .up_mem_rd_done(done[6]), .up_mem_wr_done(done[7]),
    .enum_alert_req(areq), .enum_alert_out(aout), .led_drive_out(led), .window_active(win));
  // One bus cycle; a read notes d as the expected word
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    if (!w) q.push_back(d);
    @(posedge sys_clk);
    reg_wr <= 0;
    reg_rd <= 0;
  endtask
  task close_out;
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Read data is checked in the cycle after the strobe
  always @(posedge sys_clk) rd_d <= reg_rd;
  always @(negedge sys_clk) if (rd_d) begin
    exp_v = q.pop_front();
    `CHK("rdata", exp_v, reg_rdata)
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      error_cnt++;
      close_out;
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1;
    foreach (base[i]) acc(0, 8'h80 + 8'(4 * i), 0);
    acc(0, 8'hb0, 32'h0000_c004);
    acc(0, 8'hc0, 32'h0000_0006);
    acc(1, 8'h40, 32'h1234_5678);
    acc(0, 8'h40, 32'h0000_0000);
    r = $random(seed);
    acc(1, 8'hb0, r);
    strap <= 0;
    acc(0, 8'hb0, r & 32'hff3f_0000 | 32'h0000_0004);
    areq <= 1;
    acc(1, 8'hc0, 32'hffff_ffff);
    #1;
    `CHK("led", 1'b1, led)
    `CHK("alert", 1'b1, aout)
    acc(0, 8'hc0, 32'h00ca_0006);
    acc(1, 8'hc0, 32'h0000_0000);
    #1;
    `CHK("led", 1'b0, led)
    `CHK("alert", 1'b0, aout)
    for (int i = 0; i < 8; i++) begin
      base[i] = $random(seed);
      acc(1, 8'h80 + 8'(4 * i), base[i]);
    end
    acc(1, 8'h7c, 32'h0000_0003);
    repeat (5) @(posedge sys_clk);
    acc(1, 8'h7c, 32'h0000_0064);
    acc(0, 8'h7c, 32'h0000_0063);
    // Random traffic inside the window
    repeat (40) begin
      @(posedge sys_clk);
      r = $random(seed);
      go <= r[7:0];
      for (int i = 0; i < 8; i++) nev[i] += r[i];
    end
    @(posedge sys_clk);
    go <= 8'h00;
    repeat (70) @(posedge sys_clk);
    `CHK("window", 1'b0, win)
    go <= 8'hff;
    @(posedge sys_clk);
    go <= 8'h00;
    acc(0, 8'h7c, 32'h0000_0000);
    for (int i = 0; i < 8; i++) acc(0, 8'h80 + 8'(4 * i), base[i] + nev[i]);
    close_out;
  end
endmodule
